/* File: core/video_fader_key_mixer_regs.sv */
// Video fader with colour keying, path routing, edge select and line-16 data
`timescale 1ns/10ps

// Summary of operation
// - Key 1 hit mixes MPEG and video by key-1 factor; reset 3FH.
// - Video-fade bit fades all video with look-up colour; keys disabled.
// - MPEG-fade bit fades all MPEG with look-up colour; keys disabled.
// - Key 2 hit mixes look-up colour and video by key-2 factor; reset 3FH.
// - No key hit mixes MPEG and video by no-key factor; reset 3FH.
// - Three look-up colour registers U, V, Y each reset to 80H.
// - Line-16 insertion enable bit sends data; clear at reset disables it.
// - Encoder path takes port B when clear, fader output when set.
// - RGB path takes port B when clear, fader output when set.
// - Per-port edge select: zero rising, one falling; bit 1 B, bit 0 A.
// - Two line-16 data bytes, fifth and eleventh, sent LSB first.
// - Key 1: MPEG within key-1 limits; factor times video plus rest MPEG.
// - Key 2: MPEG within key-2 limits; factor times video plus rest colour.
module video_fader_key_mixer_regs
   import fader_pkg::*;
(
   input wire logic clock,                         // Pixel clock, 25 MHz
   input wire logic nrst,                          // Synchronous reset, active low
   input wire logic [7:0] regAddr,                 // Register subaddress
   input wire logic [7:0] regWrData,               // Register write data
   input wire logic regWrite,                      // Write strobe, one cycle
   output logic [7:0] regReadData,                 // Data at regAddr, one cycle later
   input wire fader_pkg::sample_t inputPortAY,     // MPEG port luma
   input wire fader_pkg::sample_t inputPortAU,     // MPEG port U
   input wire fader_pkg::sample_t inputPortAV,     // MPEG port V
   input wire fader_pkg::sample_t inputPortBY,     // Video port luma
   input wire fader_pkg::sample_t inputPortBU,     // Video port U
   input wire fader_pkg::sample_t inputPortBV,     // Video port V
   input wire logic [23:0] key1LowLimit,           // Key 1 lower limits {V,U,Y}
   input wire logic [23:0] key1HighLimit,          // Key 1 upper limits {V,U,Y}
   input wire logic [23:0] key2LowLimit,           // Key 2 lower limits {V,U,Y}
   input wire logic [23:0] key2HighLimit,          // Key 2 upper limits {V,U,Y}
   input wire logic line16Start,                   // Pulse at the line-16 data slot
   output logic [7:0] encoderY,                    // Encoder path luma
   output logic [7:0] encoderU,                    // Encoder path U
   output logic [7:0] encoderV,                    // Encoder path V
   output logic [7:0] rgbY,                        // RGB path luma
   output logic [7:0] rgbU,                        // RGB path U
   output logic [7:0] rgbV,                        // RGB path V
   output logic line16Bit,                         // Serial line-16 data
   output logic line16Valid                        // High while line16Bit carries data
);

   // ********************************************************************
   // Declarations
   // ********************************************************************
   factor_t key1Factor_q, key1Factor_d;
   factor_t key2Factor_q, key2Factor_d;
   factor_t nokeyFactor_q, nokeyFactor_d;
   logic [1:0] fadeMode_q, fadeMode_d;
   sample_t lut_q[NUM_COMP];
   sample_t lut_d[NUM_COMP];
   logic [7:0] routing_q, routing_d;
   logic [7:0] byte5_q, byte5_d;
   logic [7:0] byte11_q, byte11_d;
   logic [7:0] readData_q, readData_d;
   sample_t portA[NUM_COMP];
   sample_t portB[NUM_COMP];
   sample_t fallA_q[NUM_COMP];
   sample_t fallB_q[NUM_COMP];
   sample_t mpegS_q[NUM_COMP];
   sample_t mpegS_d[NUM_COMP];
   sample_t videoS_q[NUM_COMP];
   sample_t videoS_d[NUM_COMP];
   logic key1Hit, key2Hit;
   factor_t mixFactor;
   sample_t mixFav[NUM_COMP];
   sample_t mixOther[NUM_COMP];
   sample_t mixOut[NUM_COMP];
   sample_t enc_q[NUM_COMP];
   sample_t enc_d[NUM_COMP];
   sample_t rgb_q[NUM_COMP];
   sample_t rgb_d[NUM_COMP];
   serial_state_t serState_q, serState_d;
   logic [15:0] shift_q, shift_d;
   logic [3:0] bitCount_q, bitCount_d;
   logic serBit_q, serBit_d;
   logic serValid_q, serValid_d;
   logic videoFade, mpegFade;

   // Component lane of a packed limit vector, Y in the low byte
   function automatic sample_t lane(input logic [23:0] vec, input int idx);
      return vec[idx * 8 +: 8];
   endfunction

   // Sample lies inside an inclusive window
   function automatic logic inWindow(input sample_t s, input sample_t lo, input sample_t hi);
      return (s >= lo) && (s <= hi);
   endfunction

   assign portA = '{inputPortAY, inputPortAU, inputPortAV};
   assign portB = '{inputPortBY, inputPortBU, inputPortBV};
   assign videoFade = fadeMode_q[1];
   assign mpegFade = fadeMode_q[0];

   // ********************************************************************
   // Register file
   // ********************************************************************
   // Reserved bits are dropped on write so they always read back as zero
   always_comb
   begin
      key1Factor_d = key1Factor_q;
      key2Factor_d = key2Factor_q;
      nokeyFactor_d = nokeyFactor_q;
      fadeMode_d = fadeMode_q;
      lut_d = lut_q;
      routing_d = routing_q;
      byte5_d = byte5_q;
      byte11_d = byte11_q;
      if (regWrite)
      begin
         case (regAddr)
            ADDR_KEY1_FACTOR: key1Factor_d = regWrData[5:0];
            ADDR_FADE_MODE:
            begin
               fadeMode_d = {regWrData[BIT_VIDEO_FADE], regWrData[BIT_MPEG_FADE]};
               key2Factor_d = regWrData[5:0];
            end
            ADDR_NOKEY_FACTOR: nokeyFactor_d = regWrData[5:0];
            ADDR_INSERT_U: lut_d[COMP_U] = regWrData;
            ADDR_INSERT_V: lut_d[COMP_V] = regWrData;
            ADDR_INSERT_Y: lut_d[COMP_Y] = regWrData;
            ADDR_ROUTING:
            begin
               routing_d = regWrData;
               routing_d[BIT_UNUSED] = 1'b0;
            end
            ADDR_LINE16_BYTE5: byte5_d = regWrData;
            ADDR_LINE16_BYTE11: byte11_d = regWrData;
            default: ;
         endcase
      end
      case (regAddr)
         ADDR_KEY1_FACTOR: readData_d = {2'b00, key1Factor_q};
         ADDR_FADE_MODE: readData_d = {fadeMode_q, key2Factor_q};
         ADDR_NOKEY_FACTOR: readData_d = {2'b00, nokeyFactor_q};
         ADDR_INSERT_U: readData_d = lut_q[COMP_U];
         ADDR_INSERT_V: readData_d = lut_q[COMP_V];
         ADDR_INSERT_Y: readData_d = lut_q[COMP_Y];
         ADDR_ROUTING: readData_d = routing_q;
         ADDR_LINE16_BYTE5: readData_d = byte5_q;
         ADDR_LINE16_BYTE11: readData_d = byte11_q;
         default: readData_d = READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         key1Factor_q <= FACTOR_RESET;
         key2Factor_q <= FACTOR_RESET;
         nokeyFactor_q <= FACTOR_RESET;
         fadeMode_q <= FADE_MODE_RESET;
         lut_q <= '{INSERT_RESET, INSERT_RESET, INSERT_RESET};
         routing_q <= ROUTING_RESET;
         byte5_q <= LINE16_BYTE_RESET;
         byte11_q <= LINE16_BYTE_RESET;
         readData_q <= READ_UNMAPPED;
      end
      else
      begin
         key1Factor_q <= key1Factor_d;
         key2Factor_q <= key2Factor_d;
         nokeyFactor_q <= nokeyFactor_d;
         fadeMode_q <= fadeMode_d;
         lut_q <= lut_d;
         routing_q <= routing_d;
         byte5_q <= byte5_d;
         byte11_q <= byte11_d;
         readData_q <= readData_d;
      end
   end

   // ********************************************************************
   // Input sampling
   // ********************************************************************
   // Falling-edge copies give the source half a period more of set-up
   always_ff @(negedge clock)
   begin
      if (!nrst)
      begin
         fallA_q <= '{8'h00, 8'h00, 8'h00};
         fallB_q <= '{8'h00, 8'h00, 8'h00};
      end
      else
      begin
         fallA_q <= portA;
         fallB_q <= portB;
      end
   end

   // Each port picks its own edge
   always_comb
   begin
      mpegS_d = routing_q[BIT_EDGE_A] ? fallA_q : portA;
      videoS_d = routing_q[BIT_EDGE_B] ? fallB_q : portB;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         mpegS_q <= '{8'h00, 8'h00, 8'h00};
         videoS_q <= '{8'h00, 8'h00, 8'h00};
      end
      else
      begin
         mpegS_q <= mpegS_d;
         videoS_q <= videoS_d;
      end
   end

   // ********************************************************************
   // Key detection and mix selection
   // ********************************************************************
   // Colour fades override keying; video fade is checked first if both set
   always_comb
   begin
      key1Hit = 1'b1;
      key2Hit = 1'b1;
      for (int i = 0; i < NUM_COMP; i++)
      begin
         key1Hit = key1Hit & inWindow(mpegS_q[i], lane(key1LowLimit, i), lane(key1HighLimit, i));
         key2Hit = key2Hit & inWindow(mpegS_q[i], lane(key2LowLimit, i), lane(key2HighLimit, i));
      end
      if (videoFade)
      begin
         mixFactor = key2Factor_q;
         mixFav = videoS_q;
         mixOther = lut_q;
      end
      else if (mpegFade)
      begin
         mixFactor = key2Factor_q;
         mixFav = mpegS_q;
         mixOther = lut_q;
      end
      else if (key1Hit)
      begin
         mixFactor = key1Factor_q;
         mixFav = videoS_q;
         mixOther = mpegS_q;
      end
      else if (key2Hit)
      begin
         mixFactor = key2Factor_q;
         mixFav = videoS_q;
         mixOther = lut_q;
      end
      else
      begin
         mixFactor = nokeyFactor_q;
         mixFav = videoS_q;
         mixOther = mpegS_q;
      end
   end

   // One blender per colour component
   for (genvar c = 0; c < NUM_COMP; c++)
   begin : gBlend
      fader_blend uBlend (
         .factor(mixFactor),
         .favoured(mixFav[c]),
         .other(mixOther[c]),
         .blended(mixOut[c])
      );
   end

   // ********************************************************************
   // Output routing
   // ********************************************************************
   always_comb
   begin
      enc_d = routing_q[BIT_ENC_SRC] ? mixOut : videoS_q;
      rgb_d = routing_q[BIT_RGB_SRC] ? mixOut : videoS_q;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         enc_q <= '{8'h00, 8'h00, 8'h00};
         rgb_q <= '{8'h00, 8'h00, 8'h00};
      end
      else
      begin
         enc_q <= enc_d;
         rgb_q <= rgb_d;
      end
   end

   // ********************************************************************
   // Line-16 data serializer
   // ********************************************************************
   // A burst in flight finishes even if the enable drops mid-way
   always_comb
   begin
      serState_d = serState_q;
      shift_d = shift_q;
      bitCount_d = bitCount_q;
      serBit_d = 1'b0;
      serValid_d = 1'b0;
      case (serState_q)
         SER_IDLE:
         begin
            if (line16Start && routing_q[BIT_LINE16_EN])
            begin
               serBit_d = byte5_q[0];
               serValid_d = 1'b1;
               shift_d = {1'b0, byte11_q, byte5_q[7:1]};
               bitCount_d = LINE16_FIRST;
               serState_d = SER_SHIFT;
            end
         end
         SER_SHIFT:
         begin
            serBit_d = shift_q[0];
            serValid_d = 1'b1;
            shift_d = {1'b0, shift_q[15:1]};
            bitCount_d = bitCount_q + 4'h1;
            if (bitCount_q == LINE16_LAST)
               serState_d = SER_IDLE;
         end
         default: serState_d = SER_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         serState_q <= SER_IDLE;
         shift_q <= 16'h0000;
         bitCount_q <= 4'h0;
         serBit_q <= 1'b0;
         serValid_q <= 1'b0;
      end
      else
      begin
         serState_q <= serState_d;
         shift_q <= shift_d;
         bitCount_q <= bitCount_d;
         serBit_q <= serBit_d;
         serValid_q <= serValid_d;
      end
   end

   assign regReadData = readData_q;
   assign encoderY = enc_q[COMP_Y];
   assign encoderU = enc_q[COMP_U];
   assign encoderV = enc_q[COMP_V];
   assign rgbY = rgb_q[COMP_Y];
   assign rgbU = rgb_q[COMP_U];
   assign rgbV = rgb_q[COMP_V];
   assign line16Bit = serBit_q;
   assign line16Valid = serValid_q;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cbAssert @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence serialStart;
      serState_q == SER_IDLE && line16Start && routing_q[BIT_LINE16_EN];
   endsequence

   sequence encFromFader;
      routing_q[BIT_ENC_SRC] && !videoFade && !mpegFade;
   endsequence

   chk_factor_reset: assert property (disable iff (1'b0) !nrst |=> key1Factor_q == FACTOR_RESET &&
      key2Factor_q == FACTOR_RESET && nokeyFactor_q == FACTOR_RESET && lut_q[COMP_V] == INSERT_RESET)
      else $error("factor or colour reset value wrong");
   chk_key1_video: assert property (encFromFader ##0 key1Hit && key1Factor_q == FACTOR_FULL
      |=> encoderY == $past(videoS_q[COMP_Y]))
      else $error("key 1 at full factor is not pure video");
   chk_key_priority: assert property (encFromFader ##0 key1Hit && key2Hit && key1Factor_q == 6'h00
      |=> encoderU == $past(mpegS_q[COMP_U]))
      else $error("key 1 did not win over key 2");
   chk_key2_colour: assert property (encFromFader ##0 !key1Hit && key2Hit && key2Factor_q == 6'h00
      |=> encoderV == $past(lut_q[COMP_V]))
      else $error("key 2 at zero factor is not look-up colour");
   chk_nokey_mpeg: assert property (encFromFader ##0 !key1Hit && !key2Hit && nokeyFactor_q == 6'h00
      |=> encoderY == $past(mpegS_q[COMP_Y]))
      else $error("no key at zero factor is not pure MPEG");
   chk_video_fade: assert property (routing_q[BIT_RGB_SRC] && videoFade && key2Factor_q == 6'h00
      |=> rgbY == $past(lut_q[COMP_Y]))
      else $error("video fade does not give look-up colour");
   chk_mpeg_fade: assert property (routing_q[BIT_RGB_SRC] && !videoFade && mpegFade && key2Factor_q == FACTOR_FULL
      |=> rgbU == $past(mpegS_q[COMP_U]))
      else $error("MPEG fade at full factor is not MPEG");
   chk_enc_bypass: assert property (!routing_q[BIT_ENC_SRC] |=> encoderV == $past(videoS_q[COMP_V]))
      else $error("encoder bypass does not carry port B");
   chk_rgb_bypass: assert property (!routing_q[BIT_RGB_SRC] |=> rgbY == $past(videoS_q[COMP_Y]))
      else $error("RGB bypass does not carry port B");
   chk_edge_rising: assert property (!routing_q[BIT_EDGE_A] |=> mpegS_q[COMP_Y] == $past(inputPortAY))
      else $error("rising-edge sample of port A wrong");
   chk_edge_falling: assert property (routing_q[BIT_EDGE_B] |=> videoS_q[COMP_U] == $past(fallB_q[COMP_U]))
      else $error("falling-edge sample of port B wrong");
   chk_line16_run: assert property (serialStart |=> line16Valid [*8] ##1 line16Valid [*8])
      else $error("line-16 burst shorter than expected");
   chk_line16_lsb: assert property (serialStart |=> line16Bit == $past(byte5_q[0]))
      else $error("line-16 burst does not start with LSB");
   chk_line16_off: assert property (serState_q == SER_IDLE && !routing_q[BIT_LINE16_EN] |=> !line16Valid)
      else $error("line-16 data sent while disabled");

endmodule // video_fader_key_mixer_regs

/* File: core/fader_pkg.sv */
// Register map, field positions, reset values and types of the video fader
package fader_pkg;

   // ********************************************************************
   // Register subaddresses
   // ********************************************************************
   localparam logic [7:0] ADDR_KEY1_FACTOR = 8'h4E;
   localparam logic [7:0] ADDR_FADE_MODE = 8'h4F;
   localparam logic [7:0] ADDR_NOKEY_FACTOR = 8'h50;
   localparam logic [7:0] ADDR_INSERT_U = 8'h51;
   localparam logic [7:0] ADDR_INSERT_V = 8'h52;
   localparam logic [7:0] ADDR_INSERT_Y = 8'h53;
   localparam logic [7:0] ADDR_ROUTING = 8'h54;
   localparam logic [7:0] ADDR_LINE16_BYTE5 = 8'h55;
   localparam logic [7:0] ADDR_LINE16_BYTE11 = 8'h56;

   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [5:0] FACTOR_RESET = 6'h3F;
   localparam logic [1:0] FADE_MODE_RESET = 2'h0;
   localparam logic [7:0] INSERT_RESET = 8'h80;
   localparam logic [7:0] ROUTING_RESET = 8'h0C;
   localparam logic [7:0] LINE16_BYTE_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int BIT_VIDEO_FADE = 7;
   localparam int BIT_MPEG_FADE = 6;
   localparam int BIT_LINE16_EN = 7;
   localparam int BIT_UNUSED = 6;
   localparam int BIT_ENC_SRC = 5;
   localparam int BIT_RGB_SRC = 4;
   localparam int BIT_EDGE_B = 1;
   localparam int BIT_EDGE_A = 0;

   // ********************************************************************
   // Pixel and blend constants
   // ********************************************************************
   localparam int NUM_COMP = 3;
   localparam int COMP_Y = 0;
   localparam int COMP_U = 1;
   localparam int COMP_V = 2;
   localparam logic [5:0] FACTOR_FULL = 6'h3F;
   localparam logic [14:0] BLEND_DIV = 15'h003F;
   localparam logic [14:0] BLEND_ROUND = 15'h001F;
   localparam logic [3:0] LINE16_FIRST = 4'h1;
   localparam logic [3:0] LINE16_LAST = 4'hF;

   typedef logic [7:0] sample_t;
   typedef logic [5:0] factor_t;
   typedef enum {SER_IDLE, SER_SHIFT} serial_state_t;

endpackage

/* File: core/fader_blend.sv */
// Weighted blend of two 8-bit samples by a 6-bit factor out of 63
`timescale 1ns/10ps
module fader_blend
   import fader_pkg::*;
(
   input wire fader_pkg::factor_t factor,      // Weight of the favoured sample
   input wire fader_pkg::sample_t favoured,    // Sample taken whole at full factor
   input wire fader_pkg::sample_t other,       // Sample taken whole at zero factor
   output logic [7:0] blended                  // Rounded mix
);

   logic [14:0] sum;

   // Linear fraction of 63 with round to nearest; 63*255 fits in 15 bits
   always_comb
   begin
      sum = 15'(factor) * 15'(favoured) + 15'(FACTOR_FULL - factor) * 15'(other) + BLEND_ROUND;
      blended = 8'(sum / BLEND_DIV);
   end

endmodule // fader_blend

/* File: bench/pixel_source.sv */
// Behavioural pixel source standing for the MPEG decoder and the video source
`timescale 1ns/10ps
module pixel_source
   import fader_pkg::*;
(
   input wire logic clock,                // Pixel clock
   input wire logic [23:0] nextA,         // Next MPEG pixel {V,U,Y}
   input wire logic [23:0] nextB,         // Next video pixel {V,U,Y}
   input wire logic edgeA,                // Port A taken on the falling edge
   input wire logic edgeB,                // Port B taken on the falling edge
   output fader_pkg::sample_t aY,         // Port A luma
   output fader_pkg::sample_t aU,         // Port A U
   output fader_pkg::sample_t aV,         // Port A V
   output fader_pkg::sample_t bY,         // Port B luma
   output fader_pkg::sample_t bU,         // Port B U
   output fader_pkg::sample_t bV          // Port B V
);
   initial {aV, aU, aY, bV, bU, bY} = '0;
   // Pixel stands around the selected edge, its inverse around the other, so a wrong edge corrupts it
   always @(clock)
   begin
      #1;
      {aV, aU, aY} = (clock == edgeA) ? nextA : ~nextA;
      {bV, bU, bY} = (clock == edgeB) ? nextB : ~nextB;
   end
endmodule // pixel_source

/* File: bench/tb_video_fader_key_mixer_regs.sv */
// Self-checking testbench of the video fader register bank and mixer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin failCount++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_video_fader_key_mixer_regs;
   import fader_pkg::*;
   logic clock = 0, nrst = 0, regWrite = 0, line16Start = 0, line16Bit, line16Valid;
   logic [7:0] regAddr = 0, regWrData = 0, regReadData, d, f1, f2, f3, mode, route = 8'h0C, b5, b11;
   logic [23:0] nextA = 0, nextB = 0, lut, k1Lo = 0, k1Hi = 0, k2Lo = 0, k2Hi = 0, mix;
   logic [7:0] aY, aU, aV, bY, bU, bV, eY, eU, eV, rY, rU, rV;
   logic k1, k2;
   int failCount = 0, nTests = 0, cycles = 0;
   logic [7:0] rstVal [10] = '{8'h3F, 8'h3F, 8'h3F, 8'h80, 8'h80, 8'h80, 8'h0C, 8'h00, 8'h00, 8'h00};
   // Corner cases: zero or full factor, key hits and fade mode per iteration
   logic [5:0] cornerF = 6'b001010;
   logic [1:0] cornerK [6] = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
   logic [1:0] cornerM [6] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b00};
   always #20 clock = ~clock;
   video_fader_key_mixer_regs i_video_fader_key_mixer_regs (.clock(clock), .nrst(nrst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regReadData(regReadData),
      .inputPortAY(aY), .inputPortAU(aU), .inputPortAV(aV), .inputPortBY(bY), .inputPortBU(bU),
      .inputPortBV(bV), .key1LowLimit(k1Lo), .key1HighLimit(k1Hi), .key2LowLimit(k2Lo),
      .key2HighLimit(k2Hi), .line16Start(line16Start), .encoderY(eY), .encoderU(eU), .encoderV(eV),
      .rgbY(rY), .rgbU(rU), .rgbV(rV), .line16Bit(line16Bit), .line16Valid(line16Valid));
   pixel_source i_pixel_source (.clock(clock), .nextA(nextA), .nextB(nextB), .edgeA(route[0]),
      .edgeB(route[1]), .aY(aY), .aU(aU),
      .aV(aV), .bY(bY), .bU(bU), .bV(bV));
   // ********************************************************************
   // Bus tasks and expectation functions
   // ********************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      #1 {regAddr, regWrData, regWrite} = {a, v, 1'b1};
      @(posedge clock);
      #1 regWrite = 0;
   endtask
   // Read data is registered, so the address is held across one edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      #1 regAddr = a;
      @(posedge clock);
      #1 v = regReadData;
   endtask
   function automatic logic [7:0] bl(input logic [5:0] f, input logic [7:0] fav, input logic [7:0] oth);
      int t;
      t = int'(f) * int'(fav) + (63 - int'(f)) * int'(oth) + 31;
      return 8'(t / 63);
   endfunction
   // Mode bits win over keys, and key 1 wins over key 2
   function automatic logic [7:0] mixc(input int c);
      logic [7:0] a, b, l;
      a = nextA[8*c+:8];
      b = nextB[8*c+:8];
      l = lut[8*c+:8];
      if (mode[1]) return bl(f2[5:0], b, l);
      if (mode[0]) return bl(f2[5:0], a, l);
      if (k1) return bl(f1[5:0], b, a);
      if (k2) return bl(f2[5:0], b, l);
      return bl(f3[5:0], b, a);
   endfunction
   task automatic endSim;
      if (failCount == 0 && nTests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Cut a hang short well beyond the expected run length
   always @(posedge clock)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         failCount++;
         endSim();
      end
   end
   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial
   begin
      void'($urandom(32'hED74));
      repeat (8) @(posedge clock);
      #1 nrst = 1;
      // Reset values of every register and of one unmapped address
      for (int i = 0; i < 10; i++)
      begin
         rd(8'h4E + 8'(i), d);
         `CHK("reset value", rstVal[i], d)
      end
      for (int n = 0; n < 60; n++)
      begin
         // First iterations reach each zero or full factor case of the mixer with both paths on the fader
         if (n < 6)
         begin
            {f1, f2, f3} = {3{2'b00, {6{cornerF[n]}}}};
            mode = {6'h00, cornerM[n]};
            route = 8'h3C | (8'($urandom) & 8'h03);
            {k1, k2} = cornerK[n];
         end
         else
         begin
            f1 = 8'($urandom) & 8'h3F;
            f2 = 8'($urandom) & 8'h3F;
            f3 = 8'($urandom) & 8'h3F;
            mode = ($urandom % 3 == 0) ? 8'($urandom % 4) : 8'h00;
            route = 8'h0C | (8'($urandom) & 8'h33);
            {k1, k2} = 2'($urandom);
         end
         lut = 24'($urandom);
         wr(ADDR_KEY1_FACTOR, f1);
         wr(ADDR_FADE_MODE, {mode[1:0], f2[5:0]});
         wr(ADDR_NOKEY_FACTOR, f3);
         wr(ADDR_INSERT_U, lut[15:8]);
         wr(ADDR_INSERT_V, lut[23:16]);
         wr(ADDR_INSERT_Y, lut[7:0]);
         wr(ADDR_ROUTING, route);
         rd(ADDR_ROUTING, d);
         `CHK("routing readback", route, d)
         nextA = 24'($urandom);
         nextB = 24'($urandom);
         // Exact inclusive limits on a hit, an empty range on a miss
         {k1Lo, k1Hi} = k1 ? {nextA, nextA} : {24'hFFFFFF, 24'h0};
         {k2Lo, k2Hi} = k2 ? {nextA, nextA} : {24'hFFFFFF, 24'h0};
         repeat (4) @(posedge clock);
         @(negedge clock);
         mix = {mixc(2), mixc(1), mixc(0)};
         `CHK("encoder pixel", route[5] ? mix : nextB, {eV, eU, eY})
         `CHK("rgb pixel", route[4] ? mix : nextB, {rV, rU, rY})
      end
      b5 = 8'($urandom);
      b11 = 8'($urandom);
      wr(ADDR_LINE16_BYTE5, b5);
      wr(ADDR_LINE16_BYTE11, b11);
      // A start while insertion is disabled sends nothing
      for (int e = 0; e < 2; e++)
      begin
         if (e == 1) wr(ADDR_ROUTING, 8'h8C);
         @(posedge clock);
         #1 line16Start = 1;
         @(posedge clock);
         #1 line16Start = 0;
         for (int i = 0; i < 16; i++)
         begin
            @(negedge clock);
            `CHK("line16 valid", 1'(e), line16Valid)
            if (e == 1) `CHK("line16 bit", (i < 8) ? b5[i] : b11[i - 8], line16Bit)
         end
         @(negedge clock);
         `CHK("line16 end", 1'b0, line16Valid)
      end
      endSim();
   end
endmodule // tb_video_fader_key_mixer_regs
